// ---- dv/fif_flag_bank_sva.sv ----
// Port assertions for the fault interrupt flag bank
`timescale 1ns/100ps
`default_nettype none
module fif_flag_bank_sva
  import fif_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Access and events
  input wire fif_req_t req,
  input wire logic [FIF_DW-1:0] rdata_q,
  input wire logic rvalid_q,
  input wire logic addr_err_q,
  input wire fif_events_t events,
  input wire logic any_fault_summary_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] a_q;
  logic quiet_q;
  // Frozen with the bank so a stalled answer keeps its address
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      a_q <= req.addr;
      quiet_q <= !req.wr && events == '0;
    end
  end
  sequence rd_take;
    clk_en && req.rd;
  endsequence
  sequence g_ans;
    rvalid_q && a_q == FIF_ADDR_GLOBAL;
  endsequence
  a_read_answer: assert property (rd_take |=> rvalid_q)
    else $error("no read answer");
  a_unmapped_read: assert property (rd_take and req.addr[7:4] != 4'h5
    |=> addr_err_q && rdata_q == 8'h00) else $error("bad unmapped");
  a_global_rsvd: assert property (g_ans |-> (rdata_q & 8'h0B) == 8'h00)
    else $error("reserved bit set");
  a_global_or: assert property (g_ans |-> rdata_q[7] == |(rdata_q & 8'h74))
    else $error("summary not OR");
  a_global_level: assert property (g_ans and quiet_q
    |-> rdata_q[7] == any_fault_summary_q) else $error("level off");
  a_det1_rsvd: assert property (rvalid_q && a_q == FIF_ADDR_DET1
    |-> (rdata_q & ~FIF_MASK_DET1) == 8'h00) else $error("det1 rsvd");
  a_det4_rsvd: assert property (rvalid_q && a_q == FIF_ADDR_DET4
    |-> (rdata_q & ~FIF_MASK_DET4) == 8'h00) else $error("det4 rsvd");
  a_event_sets: assert property (clk_en && events != '0
    |=> any_fault_summary_q) else $error("event lost");
  a_summary_hold: assert property (clk_en && !req.wr && events == '0
    |=> $stable(any_fault_summary_q)) else $error("summary moved");
  a_reset_value: assert property ($rose(resetn) |-> any_fault_summary_q)
    else $error("reset summary");
endmodule // fif_flag_bank_sva
`default_nettype wire

// ---- dv/fif_host.sv ----
// Host model issuing register reads and writes
`timescale 1ns/100ps
`default_nettype none
module fif_host
  import fif_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Access
  output var fif_req_t req,
  input wire logic [FIF_DW-1:0] rdata_q,
  input wire logic rvalid_q,
  input wire logic addr_err_q
);
  initial req = '0;
  // Idle lines show inverted values so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= {2'b01, a, d};
    @(posedge ref_clk);
    req <= {2'b00, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [9:0] r);
    @(posedge ref_clk);
    req <= {2'b10, a, 8'h00};
    @(posedge ref_clk);
    req <= {2'b00, ~a, 8'hFF};
    #1 r = {rvalid_q, addr_err_q, rdata_q};
  endtask
endmodule // fif_host
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the fault interrupt flag bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fif_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  fif_events_t events = '0;
  fif_req_t req;
  logic [7:0] rdata_q, a, m, g;
  logic rvalid_q, addr_err_q, any_fault_summary_q;
  logic [9:0] r;
  int num_errors = 0;
  int tests_run = 0;
  int pos[19] = '{7,5,4,7,6,5,4,2,1,0,7,5,4,3,2,7,6,3,2};
  always #5 ref_clk = ~ref_clk;
  fif_host u_host (.ref_clk(ref_clk), .req(req), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .addr_err_q(addr_err_q));
  fif_flag_bank u_dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .addr_err_q(addr_err_q), .events(events),
    .any_fault_summary_q(any_fault_summary_q));
  task automatic give_verdict();
    if (num_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Answer checked as valid, error flag and data together
  task automatic rc(input logic [7:0] ad, input logic [9:0] e);
    u_host.rd(ad, r);
    tests_run++;
    if (r !== e) begin
      num_errors++;
      $display("[ERR] read %h expected %h seen %h", ad, e, r);
    end
  endtask
  initial begin
    #50us;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    rc(FIF_ADDR_GLOBAL, 10'h2A0);
    rc(FIF_ADDR_DET2, 10'h240);
    rc(8'h3C, 10'h300);
    u_host.wr(FIF_ADDR_GLOBAL, 8'hFF);
    rc(FIF_ADDR_GLOBAL, 10'h2A0);
    u_host.wr(FIF_ADDR_DET2, 8'hFF);
    rc(FIF_ADDR_GLOBAL, 10'h200);
    for (int k = 0; k < 19; k++) begin
      a = k < 3 ? FIF_ADDR_DET1 : k < 10 ? FIF_ADDR_DET2 :
        k < 15 ? FIF_ADDR_DET3 : FIF_ADDR_DET4;
      g = k < 3 ? 8'hC0 : k < 10 ? 8'hA0 : k < 15 ? 8'h90 : 8'h84;
      m = 8'h01 << pos[k];
      @(posedge ref_clk);
      events <= fif_events_t'(19'h40000 >> k);
      @(posedge ref_clk);
      events <= '0;
      rc(a, {2'b10, m});
      rc(FIF_ADDR_GLOBAL, {2'b10, g});
      u_host.wr(a, ~m);
      rc(a, {2'b10, m});
      u_host.wr(a, m);
      rc(FIF_ADDR_GLOBAL, 10'h200);
    end
    // Set beats a clear landing on the same edge
    fork
      u_host.wr(FIF_ADDR_DET4, 8'hFF);
      begin
        @(posedge ref_clk);
        events.bus_wake_flag <= 1'b1;
        @(posedge ref_clk);
        events <= '0;
      end
    join
    rc(FIF_ADDR_DET4, 10'h280);
    // Events arriving while the clock enable is low must be ignored
    u_host.wr(FIF_ADDR_DET4, 8'hFF);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    events.dominant_timeout_flag <= 1'b1;
    @(posedge ref_clk);
    events <= '0;
    clk_en <= 1'b1;
    rc(FIF_ADDR_DET4, 10'h200);
    rc(FIF_ADDR_GLOBAL, 10'h200);
    give_verdict();
  end
endmodule // testbench
bind fif_flag_bank fif_flag_bank_sva u_sva (.ref_clk(ref_clk),
  .resetn(resetn), .clk_en(clk_en), .req(req), .rdata_q(rdata_q),
  .rvalid_q(rvalid_q), .addr_err_q(addr_err_q), .events(events),
  .any_fault_summary_q(any_fault_summary_q));
`default_nettype wire

// ---- hw/fif_flag_bank.sv ----
// Fault interrupt flag bank with global summary register
`timescale 1ns/100ps
`default_nettype none

module fif_flag_bank
  import fif_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Register access
  input wire fif_req_t req,
  output logic [FIF_DW-1:0] rdata_q,
  output logic rvalid_q,
  output logic addr_err_q,
  // Fault events
  input wire fif_events_t events,
  // Summary level
  output logic any_fault_summary_q
);

  logic [7:0] det1_q;
  logic [7:0] det1_d;
  logic [7:0] det2_q;
  logic [7:0] det2_d;
  logic [7:0] det3_q;
  logic [7:0] det3_d;
  logic [7:0] det4_q;
  logic [7:0] det4_d;
  logic [7:0] glob_q;
  logic [7:0] glob_d;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] set3;
  logic [7:0] set4;

  // Set wins over a clear in the same cycle; zeros written leave flags
  function automatic logic [7:0] w1c_next(
    input logic [7:0] cur,
    input logic [7:0] set,
    input logic hit,
    input logic [7:0] wdata,
    input logic [7:0] mask
  );
    logic [7:0] clr;
    clr = hit ? wdata : 8'h00;
    return ((cur & ~clr) | set) & mask;
  endfunction

  // Map event pulses to bit positions
  always_comb begin
    set1 = 8'h00;
    set2 = 8'h00;
    set3 = 8'h00;
    set4 = 8'h00;
    set1[7] = events.watchdog_event_flag;
    set1[5] = events.local_wake_flag;
    set1[4] = events.wake_error_flag;
    set2[7] = events.fault_sleep_flag;
    set2[6] = events.power_up_flag;
    set2[5] = events.regulator_overvoltage_flag;
    set2[4] = events.supply_undervoltage_flag;
    set2[2] = events.regulator_undervoltage_flag;
    set2[1] = events.regulator_transmitter_overtemp_flag;
    set2[0] = events.switch_overtemp_flag;
    set3[7] = events.serial_error_flag;
    set3[5] = events.failsafe_entry_flag;
    set3[4] = events.frame_check_error_flag;
    set3[3] = events.regulator_short_flag;
    set3[2] = events.restart_limit_flag;
    set4[7] = events.bus_wake_flag;
    set4[6] = events.dominant_timeout_flag;
    set4[3] = events.switch_overcurrent_flag;
    set4[2] = events.switch_open_load_flag;
  end

  // Write-one-to-clear update of each detail register
  always_comb begin
    det1_d = w1c_next(det1_q, set1, req.wr && req.addr == FIF_ADDR_DET1,
      req.wdata, FIF_MASK_DET1);
    det2_d = w1c_next(det2_q, set2, req.wr && req.addr == FIF_ADDR_DET2,
      req.wdata, FIF_MASK_DET2);
    // Fail-safe state is not consulted, so the clear works inside it
    det3_d = w1c_next(det3_q, set3, req.wr && req.addr == FIF_ADDR_DET3,
      req.wdata, FIF_MASK_DET3);
    det4_d = w1c_next(det4_q, set4, req.wr && req.addr == FIF_ADDR_DET4,
      req.wdata, FIF_MASK_DET4);
  end

  // Summary computed from next values so it tracks flags without lag
  always_comb begin
    glob_d = 8'h00;
    glob_d[FIF_G_DET1] = |det1_d;
    glob_d[FIF_G_DET2] = |det2_d;
    glob_d[FIF_G_DET3] = |det3_d;
    glob_d[FIF_G_DET4] = |det4_d;
    glob_d[FIF_G_ANY] = |{det1_d, det2_d, det3_d, det4_d};
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      det1_q <= FIF_RST_DET1;
      det2_q <= FIF_RST_DET2;
      det3_q <= FIF_RST_DET3;
      det4_q <= FIF_RST_DET4;
    end else if (clk_en) begin
      det1_q <= det1_d;
      det2_q <= det2_d;
      det3_q <= det3_d;
      det4_q <= det4_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      glob_q <= FIF_RST_GLOBAL;
      any_fault_summary_q <= 1'b1;
    end else if (clk_en) begin
      glob_q <= glob_d;
      any_fault_summary_q <= glob_d[FIF_G_ANY];
    end
  end

  // Read port; unmapped reads return zero and flag an error
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      addr_err_q <= 1'b0;
    end else if (clk_en) begin
      rvalid_q <= req.rd;
      addr_err_q <= 1'b0;
      rdata_q <= 8'h00;
      if (req.rd) begin
        if (req.addr == FIF_ADDR_GLOBAL) begin
          rdata_q <= glob_q;
        end else if (req.addr == FIF_ADDR_DET1) begin
          rdata_q <= det1_q;
        end else if (req.addr == FIF_ADDR_DET2) begin
          rdata_q <= det2_q;
        end else if (req.addr == FIF_ADDR_DET3) begin
          rdata_q <= det3_q;
        end else if (req.addr == FIF_ADDR_DET4) begin
          rdata_q <= det4_q;
        end else begin
          addr_err_q <= 1'b1;
        end
      end
    end
  end

endmodule // fif_flag_bank

`default_nettype wire

// ---- hw/fif_pkg.sv ----
// Package for the fault interrupt flag bank: offsets, layouts, reset values
package fif_pkg;

  localparam int FIF_AW = 8;
  localparam int FIF_DW = 8;

  // Register offsets
  localparam logic [7:0] FIF_ADDR_GLOBAL = 8'h50;
  localparam logic [7:0] FIF_ADDR_DET1 = 8'h51;
  localparam logic [7:0] FIF_ADDR_DET2 = 8'h52;
  localparam logic [7:0] FIF_ADDR_DET3 = 8'h53;
  localparam logic [7:0] FIF_ADDR_DET4 = 8'h5A;

  // Global summary bit positions
  localparam int FIF_G_ANY = 7;
  localparam int FIF_G_DET1 = 6;
  localparam int FIF_G_DET2 = 5;
  localparam int FIF_G_DET3 = 4;
  localparam int FIF_G_DET4 = 2;

  // Implemented bits per detail register
  localparam logic [7:0] FIF_MASK_DET1 = 8'hB0;
  localparam logic [7:0] FIF_MASK_DET2 = 8'hF7;
  localparam logic [7:0] FIF_MASK_DET3 = 8'hBC;
  localparam logic [7:0] FIF_MASK_DET4 = 8'hCC;

  // Reset values (power-up flag set in second register)
  localparam logic [7:0] FIF_RST_DET1 = 8'h00;
  localparam logic [7:0] FIF_RST_DET2 = 8'h40;
  localparam logic [7:0] FIF_RST_DET3 = 8'h00;
  localparam logic [7:0] FIF_RST_DET4 = 8'h00;
  localparam logic [7:0] FIF_RST_GLOBAL = 8'hA0;

  // Hardware event pulses, one bit per flag
  typedef struct packed {
    logic watchdog_event_flag;
    logic local_wake_flag;
    logic wake_error_flag;
    logic fault_sleep_flag;
    logic power_up_flag;
    logic regulator_overvoltage_flag;
    logic supply_undervoltage_flag;
    logic regulator_undervoltage_flag;
    logic regulator_transmitter_overtemp_flag;
    logic switch_overtemp_flag;
    logic serial_error_flag;
    logic failsafe_entry_flag;
    logic frame_check_error_flag;
    logic regulator_short_flag;
    logic restart_limit_flag;
    logic bus_wake_flag;
    logic dominant_timeout_flag;
    logic switch_overcurrent_flag;
    logic switch_open_load_flag;
  } fif_events_t;

  // Register access request from the serial interface
  typedef struct packed {
    logic rd;
    logic wr;
    logic [FIF_AW-1:0] addr;
    logic [FIF_DW-1:0] wdata;
  } fif_req_t;

endpackage : fif_pkg
